//--- dac5_pkg.sv
// constants and carrier types for the three five-bit converter controls
// assumes a classic wishbone slave with 32-bit data, one word per register
// What this block does
// - three identical converter controls, numbered two to four, each with two registers and two pins.
// - the converter is active only while bit 7 of control register zero is set.
// - control register one holds a five-bit level code choosing one of 32 steps.
// - while enabled the ladder tap equals the level code in 32nds of the source span above ground.
// - while disabled with low-power select set and code all ones the output is the positive source.
// - while disabled with low-power select clear and code all zeros the output is ground.
// - bits 3-2 choose supply (00), external reference pin (01), fixed reference buffer two (10); 11 reserved.
// - bit 5 routes the level to pin one and bit 4 routes it to pin two.
// - a routed pin has its digital output driver and input threshold detector disabled.
// - a digital read of a routed pin returns zero.
// - waking from sleep leaves control register zero unchanged.
// - any reset disables the converter, unroutes the pins and clears the code; all bits reset to zero.
// - unimplemented bits read zero: bits 6 and 1-0 of register zero, bits 7-5 of register one.
package dac5_pkg;
    localparam int unsigned NUM_INST = 3;
    localparam int unsigned FIRST_INST_NUM = 2;
    localparam int unsigned CODE_W = 5;
    localparam int unsigned LADDER_STEPS = 32;
    // byte offsets: instance n at INST_STRIDE*n, two words each
    localparam logic [7:0] INST_STRIDE = 8'h08;
    localparam logic [7:0] CTRL0_OFS = 8'h00;
    localparam logic [7:0] CTRL1_OFS = 8'h04;
    localparam logic [7:0] LPS_OFS = 8'h20;
    localparam int unsigned ADDR_W = 8;
    // control register zero fields
    localparam int unsigned ON_BIT = 7;
    localparam int unsigned PIN1_BIT = 5;
    localparam int unsigned PIN2_BIT = 4;
    localparam int unsigned PSS_LSB = 2;
    localparam logic [7:0] CTRL0_MASK = 8'hbc;
    localparam logic [7:0] CTRL1_MASK = 8'h1f;
    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [1:0] PSS_SUPPLY = 2'h0;
    localparam logic [1:0] PSS_EXT_REF = 2'h1;
    localparam logic [1:0] PSS_FIXED_REF = 2'h2;
    localparam logic [1:0] PSS_RESERVED = 2'h3;
    localparam logic [CODE_W-1:0] CODE_ALL_ONES = 5'h1f;
    localparam logic [CODE_W-1:0] CODE_ALL_ZERO = 5'h00;

    typedef enum logic [3:0] {
        SRC_NONE = 4'h1,
        SRC_SUPPLY = 4'h2,
        SRC_EXT_REF = 4'h4,
        SRC_FIXED_REF = 4'h8
    } source_t;

    typedef struct packed {
        logic ladder_on;
        logic [CODE_W-1:0] tap;
        logic tie_top;
        logic tie_bottom;
        source_t source;
        logic pin_one_route;
        logic pin_two_route;
    } analog_ctl_t;

    typedef struct packed {
        logic converter_on;
        logic pin_one_route;
        logic pin_two_route;
        logic [1:0] positive_source_select;
        logic low_power_state_select;
        logic [CODE_W-1:0] level_code;
    } dac_cfg_t;
endpackage

//--- dac5_channel.sv
// one converter instance: turns stored fields into ladder and pin controls
// assumes fields come from registers on the same clock
module dac5_channel
    import dac5_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire dac_cfg_t cfg_i,
    input wire logic pin_one_din_i,
    input wire logic pin_two_din_i,
    output analog_ctl_t analog_o,
    output logic pin_one_rd_o,
    output logic pin_two_rd_o
);
    analog_ctl_t analog_nxt;
    logic [1:0] pin_sync1_r;
    logic [1:0] pin_sync2_r;

    function automatic source_t decode_source(input logic [1:0] sel);
        case (sel)
            PSS_SUPPLY: decode_source = SRC_SUPPLY;
            PSS_EXT_REF: decode_source = SRC_EXT_REF;
            PSS_FIXED_REF: decode_source = SRC_FIXED_REF;
            default: decode_source = SRC_NONE; // reserved: leave ladder floating
        endcase
    endfunction

    always_comb begin
        analog_nxt = '0;
        analog_nxt.source = decode_source(cfg_i.positive_source_select);
        analog_nxt.ladder_on = cfg_i.converter_on;
        analog_nxt.tap = cfg_i.level_code;
        // disabled ladder parks at a rail only for the matching code
        analog_nxt.tie_top = !cfg_i.converter_on &&
            cfg_i.low_power_state_select &&
            cfg_i.level_code == CODE_ALL_ONES;
        analog_nxt.tie_bottom = !cfg_i.converter_on &&
            !cfg_i.low_power_state_select &&
            cfg_i.level_code == CODE_ALL_ZERO;
        analog_nxt.pin_one_route = cfg_i.pin_one_route;
        analog_nxt.pin_two_route = cfg_i.pin_two_route;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            analog_o <= '0;
            analog_o.source <= SRC_SUPPLY;
        end else begin
            analog_o <= analog_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_sync1_r <= 2'h0;
            pin_sync2_r <= 2'h0;
        end else begin
            pin_sync1_r <= {pin_two_din_i, pin_one_din_i};
            pin_sync2_r <= pin_sync1_r;
        end
    end

    // routed pin has its threshold detector cut off, reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_one_rd_o <= 1'b0;
            pin_two_rd_o <= 1'b0;
        end else begin
            pin_one_rd_o <= pin_sync2_r[0] && !cfg_i.pin_one_route;
            pin_two_rd_o <= pin_sync2_r[1] && !cfg_i.pin_two_route;
        end
    end
endmodule

//--- dac5_ctrl.sv
// wishbone register file and three converter instances
// assumes a classic wishbone master on clk_i; sleep never resets this block
module dac5_ctrl
    import dac5_pkg::*;
#(
    parameter int unsigned N_INST = NUM_INST
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic [N_INST-1:0] pin_one_din_i,
    input wire logic [N_INST-1:0] pin_two_din_i,
    output logic [N_INST-1:0] pin_one_rd_o,
    output logic [N_INST-1:0] pin_two_rd_o,
    output logic [N_INST-1:0] pin_one_dig_oe_off_o,
    output logic [N_INST-1:0] pin_two_dig_oe_off_o,
    output analog_ctl_t [N_INST-1:0] analog_o
);
    logic [7:0] ctrl0_r [N_INST];
    logic [7:0] ctrl1_r [N_INST];
    logic [N_INST-1:0] lps_r;
    logic req;
    logic wr_go;
    logic hit;
    logic [31:0] rd_nxt;
    logic err_nxt;

    function automatic logic [7:0] inst_base(input int unsigned n);
        inst_base = 8'(n * INST_STRIDE);
    endfunction

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

    always_comb begin
        rd_nxt = 32'h0;
        hit = 1'b0;
        for (int unsigned n = 0; n < N_INST; n++) begin
            if (wb_adr_i == inst_base(n) + CTRL0_OFS) begin
                hit = 1'b1;
                rd_nxt = {24'h0, ctrl0_r[n] & CTRL0_MASK};
            end
            if (wb_adr_i == inst_base(n) + CTRL1_OFS) begin
                hit = 1'b1;
                rd_nxt = {24'h0, ctrl1_r[n] & CTRL1_MASK};
            end
        end
        if (wb_adr_i == LPS_OFS) begin
            hit = 1'b1;
            rd_nxt = {{(32 - N_INST){1'b0}}, lps_r};
        end
        err_nxt = !hit;
    end

    assign wr_go = req && wb_we_i && hit && wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int unsigned n = 0; n < N_INST; n++) begin
                ctrl0_r[n] <= CTRL0_RST;
                ctrl1_r[n] <= CTRL1_RST;
            end
        end else if (wr_go) begin
            for (int unsigned n = 0; n < N_INST; n++) begin
                if (wb_adr_i == inst_base(n) + CTRL0_OFS)
                    ctrl0_r[n] <= wb_dat_i[7:0] & CTRL0_MASK;
                if (wb_adr_i == inst_base(n) + CTRL1_OFS)
                    ctrl1_r[n] <= wb_dat_i[7:0] & CTRL1_MASK;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            lps_r <= '0;
        else if (wr_go && wb_adr_i == LPS_OFS)
            lps_r <= wb_dat_i[N_INST-1:0];
    end

    // one wait state: ack in the cycle after the request is seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req && !err_nxt;
            wb_err_o <= req && err_nxt;
            wb_dat_o <= (req && !wb_we_i && !err_nxt) ? rd_nxt : 32'h0;
        end
    end

    // digital driver held off while routed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_one_dig_oe_off_o <= '0;
            pin_two_dig_oe_off_o <= '0;
        end else begin
            for (int unsigned n = 0; n < N_INST; n++) begin
                pin_one_dig_oe_off_o[n] <= ctrl0_r[n][PIN1_BIT];
                pin_two_dig_oe_off_o[n] <= ctrl0_r[n][PIN2_BIT];
            end
        end
    end

    for (genvar g = 0; g < N_INST; g++) begin : g_inst
        dac_cfg_t cfg;
        assign cfg = '{converter_on: ctrl0_r[g][ON_BIT],
            pin_one_route: ctrl0_r[g][PIN1_BIT],
            pin_two_route: ctrl0_r[g][PIN2_BIT],
            positive_source_select: ctrl0_r[g][PSS_LSB+1:PSS_LSB],
            low_power_state_select: lps_r[g],
            level_code: ctrl1_r[g][CODE_W-1:0]};
        dac5_channel u_chan (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .cfg_i(cfg),
            .pin_one_din_i(pin_one_din_i[g]),
            .pin_two_din_i(pin_two_din_i[g]),
            .analog_o(analog_o[g]),
            .pin_one_rd_o(pin_one_rd_o[g]),
            .pin_two_rd_o(pin_two_rd_o[g])
        );
    end
endmodule

//--- dac5_ctrl_asserts.sv
// bus and pin relations of the three converter controls
// assumes one clock, reset high and synchronous, bound into dac5_ctrl
module dac5_ctrl_asserts
    import dac5_pkg::*;
#(
    parameter int unsigned N_INST = NUM_INST
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic [N_INST-1:0] pin_one_rd_o,
    input wire logic [N_INST-1:0] pin_two_rd_o,
    input wire logic [N_INST-1:0] pin_one_dig_oe_off_o,
    input wire logic [N_INST-1:0] pin_two_dig_oe_off_o,
    input wire analog_ctl_t [N_INST-1:0] analog_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    a_answer_has_req: assert property ((wb_ack_o || wb_err_o) |->
        $past(wb_cyc_i && wb_stb_i)) else $error("answer without request");
    a_single_answer: assert property (!(wb_ack_o && wb_err_o))
        else $error("ack and err together");
    a_err_one_cycle: assert property (wb_err_o |=> !wb_err_o)
        else $error("err held past one cycle");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    for (genvar i = 0; i < N_INST; i++) begin : g_ch
        a_route_pin_one: assert property (pin_one_dig_oe_off_o[i] ==
            analog_o[i].pin_one_route) else $error("pin one driver");
        a_route_pin_two: assert property (pin_two_dig_oe_off_o[i] ==
            analog_o[i].pin_two_route) else $error("pin two driver");
        a_read_one_zero: assert property (pin_one_dig_oe_off_o[i] |->
            !pin_one_rd_o[i]) else $error("routed pin one reads high");
        a_read_two_zero: assert property (pin_two_dig_oe_off_o[i] |->
            !pin_two_rd_o[i]) else $error("routed pin two reads high");
        a_tie_when_off: assert property ((analog_o[i].tie_top ||
            analog_o[i].tie_bottom) |-> !analog_o[i].ladder_on)
            else $error("ladder tied while on");
    end
    c_err: cover property (wb_err_o);
    c_on: cover property (analog_o[0].ladder_on);
    c_top: cover property (analog_o[0].tie_top);
    c_route: cover property (pin_one_dig_oe_off_o[0]);
endmodule
bind dac5_ctrl dac5_ctrl_asserts #(.N_INST(N_INST)) i_dac5_ctrl_asserts (.*);

//--- dac5_ctrl_tb.sv
// random and corner settings written over wishbone, then checked
// assumes the checker file binds itself into dac5_ctrl
module dac5_ctrl_tb
    import dac5_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, err, e;
    logic [7:0] adr = 8'h00, m0 [3], m1 [3];
    logic [3:0] sel = 4'h0, wsel = 4'hf;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [2:0] d1 = 3'h0, d2 = 3'h0, rd1, rd2, off1, off2, mlps;
    analog_ctl_t [2:0] ana;
    int err_total = 0, total_checks = 0, seed = 32'h7124e084;
    dac5_ctrl i_dac5_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .pin_one_din_i(d1), .pin_two_din_i(d2), .pin_one_rd_o(rd1),
        .pin_two_rd_o(rd2), .pin_one_dig_oe_off_o(off1),
        .pin_two_dig_oe_off_o(off2), .analog_o(ana));
    initial forever #2 clk_i = ~clk_i;
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    // values read right after the edge are the ones sampled at it
    task automatic xfer(input logic w, input int a, input logic [7:0] d);
        int n = 0;
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, 8'(a), 24'h0, d, wsel};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        q = rdat;
        e = err;
        if (n == 20) err_total++;
        {cyc, stb} <= 2'b00;
        @(posedge clk_i);
    endtask
    function automatic analog_ctl_t expa(logic [7:0] c0, c1, logic l);
        analog_ctl_t a;
        a.ladder_on = c0[7];
        a.tap = c0[7] ? c1[4:0] : 5'h00;
        a.tie_top = !c0[7] && l && c1[4:0] == 5'h1f;
        a.tie_bottom = !c0[7] && !l && c1[4:0] == 5'h00;
        a.source = c0[3:2] == 2'h3 ? SRC_NONE : source_t'(4'h2 << c0[3:2]);
        a.pin_one_route = c0[5];
        a.pin_two_route = c0[4];
        return a;
    endfunction
    task automatic chk_ana();
        analog_ctl_t x, g;
        for (int i = 0; i < 3; i++) begin
            x = expa(m0[i], m1[i], mlps[i]);
            g = ana[i];
            // tap is free while the ladder is off
            if (!x.ladder_on) g.tap = 5'h00;
            chk(32'(g), 32'(x));
            chk(32'(off1[i]), 32'(m0[i][5]));
            chk(32'(off2[i]), 32'(m0[i][4]));
            chk(32'(rd1[i]), 32'(d1[i] & !m0[i][5]));
            chk(32'(rd2[i]), 32'(d2[i] & !m0[i][4]));
        end
    endtask
    task automatic chk_regs();
        for (int i = 0; i < 3; i++) begin
            xfer(0, 8 * i, 8'h00);
            chk(q, {24'h0, m0[i]});
            xfer(0, 8 * i + 4, 8'h00);
            chk(q, {24'h0, m1[i]});
        end
        xfer(0, 'h20, 8'h00);
        chk(q, {29'h0, mlps});
    endtask
    task automatic clear_model();
        m0 = '{default: 8'h00};
        m1 = '{default: 8'h00};
        mlps = 3'h0;
    endtask
    initial begin
        #40000;
        err_total++;
        conclude();
    end
    initial begin
        logic [7:0] c0, c1;
        logic [2:0] l;
        int i;
        clear_model();
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        chk_regs();
        $display("test reset values done");
        for (int k = 0; k < 12; k++) begin
            c0 = 8'($random(seed));
            c1 = 8'($random(seed));
            l = 3'($random(seed));
            // reserved source, stray bits, off at all ones
            if (k == 0) {c0, c1, l} = {8'h7f, 8'hff, 3'h7};
            if (k == 1) {c0, c1, l} = {8'h30, 8'h00, 3'h0};
            d1 <= 3'($random(seed));
            d2 <= 3'($random(seed));
            i = k % 3;
            xfer(1, 8 * i, c0);
            xfer(1, 8 * i + 4, c1);
            xfer(1, 'h20, {5'h0, l});
            m0[i] = c0 & 8'hbc;
            m1[i] = c1 & 8'h1f;
            mlps = l;
            chk_ana();
            chk_regs();
        end
        $display("test random settings done");
        xfer(1, 'h40, 8'hff);
        chk(32'(e), 32'h1);
        chk_regs();
        $display("test unmapped address done");
        // low byte lane off: acked but nothing stored
        wsel = 4'he;
        xfer(1, 8, 8'hff);
        wsel = 4'hf;
        chk_regs();
        $display("test masked byte lane done");
        rst_i <= 1;
        @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        clear_model();
        chk_regs();
        chk_ana();
        $display("test mid-run reset done");
        conclude();
    end
endmodule
